// ===== logic/nibble_unit_map.vh
// Register offsets, field positions, opcodes and reset values of the instruction unit
`ifndef NIBBLE_UNIT_MAP_VH
`define NIBBLE_UNIT_MAP_VH

// Register port offsets (word index)
`define OFS_INSTR        4'h0
`define OFS_AB           4'h1
`define OFS_XYD          4'h2
`define OFS_E            4'h3
`define OFS_TCTRL        4'h4
`define OFS_PULL         4'h5
`define OFS_FLAGS        4'h6

// Status word bit positions at OFS_INSTR
`define STAT_BUSY_BIT    1
`define STAT_SKIP_BIT    0

// Flags word bit positions at OFS_FLAGS
`define FLG_WDF_BIT      2
`define FLG_TOP_BIT      1
`define FLG_CARRY_BIT    0

// Single-code opcodes
`define OP_COPY_B_TO_A   9'h01E
`define OP_COPY_A_TO_B   9'h00E
`define OP_COPY_Y_TO_A   9'h01F
`define OP_COPY_A_TO_Y   9'h00C
`define OP_WRITE_E       9'h01A
`define OP_READ_E        9'h02A
`define OP_PAGE_SEL      9'h029
`define OP_READ_T1       9'h057
`define OP_READ_T2       9'h050
`define OP_RELOAD_T2     9'h053
`define OP_GATE_SEL      9'h058
`define OP_PULL_FIRST    9'h02D
`define OP_PULL_SECOND   9'h08E
`define OP_T1_CTRL       9'h05B
`define OP_T2_CTRL       9'h05A
`define OP_TOP_BIT_SET   9'h082
`define OP_WDT_CLEAR     9'h00F
`define OP_GATE_OP       9'h041

// Opcode families, upper seven bits (low two bits are j)
`define GRP_LOAD_RAM     7'h19
`define GRP_SWAP         7'h18
`define GRP_SWAP_DOWN    7'h1B
`define GRP_SWAP_UP      7'h1A
// Table fetch, upper five bits (low four bits are the page)
`define GRP_TABLE        5'h09

// Gate function codes
`define GATE_XOR         2'h0
`define GATE_OR          2'h1
`define GATE_AND         2'h2

// Reset values and timing
`define RST_NIBBLE       4'h0
`define RST_BYTE         8'h00
`define Y_WRAP_DOWN      4'hF
`define Y_WRAP_UP        4'h0
`define FETCH_CYCLES     2'h3

`endif

// ===== logic/rom_fetch_seq.v
// Three-cycle ROM table fetch sequencer with stack push and pop
`include "nibble_unit_map.vh"

module rom_fetch_seq (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // request
  input  wire        start,
  input  wire [10:0] fetch_addr,
  // ROM port, data valid in the cycle after rom_rd
  output reg  [10:0] rom_addr,
  output reg         rom_rd,
  input  wire [8:0]  rom_rdata,
  // stack
  output reg         stack_push,
  output reg         stack_pop,
  // result
  output reg         done,
  output reg  [8:0]  word
);

  reg [1:0] cnt_reg;

  always @(posedge ref_clk) begin
    if (reset) begin
      cnt_reg    <= 2'h0;
      rom_addr   <= 11'h000;
      rom_rd     <= 1'b0;
      stack_push <= 1'b0;
      stack_pop  <= 1'b0;
      done       <= 1'b0;
      word       <= 9'h000;
    end else begin
      rom_rd     <= 1'b0;
      stack_push <= 1'b0;
      stack_pop  <= 1'b0;
      done       <= 1'b0;
      if (start && cnt_reg == 2'h0) begin
        // The return address goes to the stack while the table word is read
        cnt_reg    <= `FETCH_CYCLES;
        rom_addr   <= fetch_addr;
        rom_rd     <= 1'b1;
        stack_push <= 1'b1;
      end else if (cnt_reg != 2'h0) begin
        cnt_reg <= cnt_reg - 2'h1;
        if (cnt_reg == 2'h2) begin
          word      <= rom_rdata;
          done      <= 1'b1;
          stack_pop <= 1'b1;
        end
      end
    end
  end

endmodule // rom_fetch_seq

// ===== logic/nibble_transfer_instruction_unit.v
// Transfer, table fetch, control write and RAM exchange instruction unit
//
// Our own choices: the strobed register port and the address map.
`include "nibble_unit_map.vh"

// Overview of operation
// - Timer-two reload copies low reload register into timer 2, upper and lower nibbles.
// - Copy-upper-to-working puts B into A in one cycle, carry unchanged.
// - Read-timer loads timer count: upper nibble into B, lower nibble into A.
// - Read-operand-pair copies E bits 7..4 into B and bits 3..0 into A.
// - Table fetch takes three cycles, reads ROM at page, D, A into B and A.
// - With top-bit enable set, table fetch also loads ROM bit 8 into carry.
// - Load-from-RAM puts addressed nibble into A, then X becomes X xor j.
// - Copy-digit-pointer places Y into A in a single cycle.
// - Copy-working-to-upper places A into B, A and carry unchanged.
// - Load-page-select writes A bits 2..0 into the three-bit D register.
// - Write-operand-pair loads E with B in upper bits, A in lower bits.
// - Set-gate-function copies A bits 1..0 into the gate function select register.
// - Pull-down control instructions copy all of A into first or second register.
// - Set-timer-one-control writes A bits 2..0 into the timer 1 control register.
// - Set-timer-two-control writes all four A bits into timer 2 control.
// - Load-digit-pointer copies A into Y in a single cycle.
// - Enable-ROM-top-bit sets the flag letting table fetch load bit 8 to carry.
// - Watchdog-clear resets the first watchdog flag to zero, unless an expiry lands in the same cycle.
// - Swap exchanges A with addressed RAM nibble, X becomes X xor j, no skip.
// - Swap-step-down also decrements Y and skips next instruction when Y wraps to 15.
// - Swap-step-up also increments Y and skips next instruction when Y wraps to 0.
// - Table fetch occupies one stack level, pushing then restoring the program counter.
// - Gate function select chooses the logic applied between A and E.
module nibble_transfer_instruction_unit (
  // clock and reset
  input  wire        ref_clk,
  input  wire        reset,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // timers and watchdog
  input  wire [7:0]  timer_one_count,
  input  wire [7:0]  timer_two_count,
  input  wire [7:0]  timer_two_low_reload,
  input  wire        watchdog_expire,
  output reg         reload_timer_two_low,
  output reg  [7:0]  timer_two_load_value,
  output reg  [2:0]  timer_one_control,
  output reg  [3:0]  timer_two_control,
  // control registers and flags
  output reg  [1:0]  gate_function_select,
  output reg  [3:0]  pulldown_ctrl_first,
  output reg  [3:0]  pulldown_ctrl_second,
  output reg         watchdog_flag_one,
  output reg         rom_top_bit_enable,
  output reg         carry_bit,
  // RAM, read combinational at memory_pointer
  output wire [5:0]  memory_pointer,
  input  wire [3:0]  ram_rdata,
  output reg  [5:0]  ram_waddr,
  output reg  [3:0]  ram_wdata,
  output reg         ram_we,
  // ROM and subroutine stack
  output wire [10:0] rom_addr,
  output wire        rom_rd,
  input  wire [8:0]  rom_rdata,
  output wire        stack_push,
  output wire        stack_pop
);

  // Architectural registers
  reg  [3:0] a_reg;
  reg  [3:0] b_reg;
  reg  [1:0] x_reg;
  reg  [3:0] y_reg;
  reg  [2:0] d_reg;
  reg  [7:0] e_reg;
  reg        skip_reg;
  reg        busy_reg;

  // Next values
  reg  [3:0] a_next;
  reg  [3:0] b_next;
  reg  [1:0] x_next;
  reg  [3:0] y_next;
  reg  [2:0] d_next;
  reg  [7:0] e_next;
  reg        skip_next;
  reg        carry_next;
  reg        top_bit_next;
  reg        wdf_next;
  reg  [1:0] gate_next;
  reg  [3:0] pull_first_next;
  reg  [3:0] pull_second_next;
  reg  [2:0] t1_ctrl_next;
  reg  [3:0] t2_ctrl_next;
  reg        reload_next;
  reg        we_next;
  reg  [3:0] wdata_next;

  wire        issue;
  wire        exec;
  wire [8:0]  op;
  wire [1:0]  j;
  wire        start;
  wire        fetch_done;
  wire [8:0]  fetch_word;
  wire [3:0]  mem_nibble;
  wire [3:0]  y_dec;
  wire [3:0]  y_inc;

  assign op             = reg_wdata[8:0];
  assign j              = op[1:0];
  assign memory_pointer = {x_reg, y_reg};
  assign y_dec          = y_reg - 4'h1;
  assign y_inc          = y_reg + 4'h1;

  // Instructions written while a table fetch runs are dropped
  assign issue = reg_wr && (reg_addr == `OFS_INSTR) && !busy_reg;
  assign exec  = issue && !skip_reg;
  assign start = exec && (op[8:4] == `GRP_TABLE);

  // A write issued one cycle earlier has not reached the RAM yet, so forward it
  assign mem_nibble = (ram_we && ram_waddr == memory_pointer) ? ram_wdata : ram_rdata;

  function [3:0] gate_result;
    input [1:0] sel;
    input [3:0] lhs;
    input [3:0] rhs;
    begin
      if (sel == `GATE_XOR) begin
        gate_result = lhs ^ rhs;
      end else if (sel == `GATE_OR) begin
        gate_result = lhs | rhs;
      end else if (sel == `GATE_AND) begin
        gate_result = lhs & rhs;
      end else begin
        gate_result = lhs;
      end
    end
  endfunction

  always @* begin
    a_next      = a_reg;
    b_next      = b_reg;
    x_next      = x_reg;
    y_next      = y_reg;
    d_next      = d_reg;
    e_next      = e_reg;
    skip_next   = skip_reg;
    carry_next       = carry_bit;
    top_bit_next     = rom_top_bit_enable;
    wdf_next         = watchdog_flag_one;
    gate_next        = gate_function_select;
    pull_first_next  = pulldown_ctrl_first;
    pull_second_next = pulldown_ctrl_second;
    t1_ctrl_next     = timer_one_control;
    t2_ctrl_next     = timer_two_control;
    reload_next = 1'b0;
    we_next     = 1'b0;
    wdata_next  = ram_wdata;
    // A pending skip is used up by the next issued instruction
    if (issue) begin
      skip_next = 1'b0;
    end
    if (exec) begin
      case (op[8:2])
        `GRP_LOAD_RAM: begin
          a_next = mem_nibble;
          x_next = x_reg ^ j;
        end
        `GRP_SWAP, `GRP_SWAP_DOWN, `GRP_SWAP_UP: begin
          a_next     = mem_nibble;
          we_next    = 1'b1;
          wdata_next = a_reg;
          x_next     = x_reg ^ j;
          if (op[8:2] == `GRP_SWAP_DOWN) begin
            y_next    = y_dec;
            skip_next = (y_dec == `Y_WRAP_DOWN);
          end else if (op[8:2] == `GRP_SWAP_UP) begin
            y_next    = y_inc;
            skip_next = (y_inc == `Y_WRAP_UP);
          end
        end
        default: begin
          case (op)
            `OP_COPY_B_TO_A: begin
              a_next = b_reg;
            end
            `OP_COPY_A_TO_B: begin
              b_next = a_reg;
            end
            `OP_COPY_Y_TO_A: begin
              a_next = y_reg;
            end
            `OP_COPY_A_TO_Y: begin
              y_next = a_reg;
            end
            `OP_WRITE_E: begin
              e_next = {b_reg, a_reg};
            end
            `OP_READ_E: begin
              b_next = e_reg[7:4];
              a_next = e_reg[3:0];
            end
            `OP_PAGE_SEL: begin
              d_next = a_reg[2:0];
            end
            `OP_READ_T1: begin
              b_next = timer_one_count[7:4];
              a_next = timer_one_count[3:0];
            end
            `OP_READ_T2: begin
              b_next = timer_two_count[7:4];
              a_next = timer_two_count[3:0];
            end
            `OP_RELOAD_T2: begin
              reload_next = 1'b1;
            end
            `OP_GATE_SEL: begin
              gate_next = a_reg[1:0];
            end
            `OP_PULL_FIRST: begin
              pull_first_next = a_reg;
            end
            `OP_PULL_SECOND: begin
              pull_second_next = a_reg;
            end
            `OP_T1_CTRL: begin
              t1_ctrl_next = a_reg[2:0];
            end
            `OP_T2_CTRL: begin
              t2_ctrl_next = a_reg;
            end
            `OP_TOP_BIT_SET: begin
              top_bit_next = 1'b1;
            end
            `OP_WDT_CLEAR: begin
              wdf_next = 1'b0;
            end
            `OP_GATE_OP: begin
              a_next = gate_result(gate_function_select, a_reg, e_reg[3:0]);
            end
            default: begin
              a_next = a_reg;
            end
          endcase
        end
      endcase
    end
    // Table word lands after the third fetch cycle
    if (fetch_done) begin
      b_next = fetch_word[7:4];
      a_next = fetch_word[3:0];
      if (rom_top_bit_enable) begin
        carry_next = fetch_word[8];
      end
    end
    // The watchdog's own set beats a clear issued in the same cycle
    if (watchdog_expire) begin
      wdf_next = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      a_reg                <= `RST_NIBBLE;
      b_reg                <= `RST_NIBBLE;
      x_reg                <= 2'h0;
      y_reg                <= `RST_NIBBLE;
      d_reg                <= 3'h0;
      e_reg                <= `RST_BYTE;
      skip_reg             <= 1'b0;
      busy_reg             <= 1'b0;
      carry_bit            <= 1'b0;
      rom_top_bit_enable   <= 1'b0;
      watchdog_flag_one    <= 1'b0;
      gate_function_select <= 2'h0;
      pulldown_ctrl_first  <= `RST_NIBBLE;
      pulldown_ctrl_second <= `RST_NIBBLE;
      timer_one_control    <= 3'h0;
      timer_two_control    <= `RST_NIBBLE;
      reload_timer_two_low <= 1'b0;
      timer_two_load_value <= `RST_BYTE;
      ram_we               <= 1'b0;
      ram_waddr            <= 6'h00;
      ram_wdata            <= `RST_NIBBLE;
    end else begin
      a_reg                <= a_next;
      b_reg                <= b_next;
      x_reg                <= x_next;
      y_reg                <= y_next;
      d_reg                <= d_next;
      e_reg                <= e_next;
      skip_reg             <= skip_next;
      carry_bit            <= carry_next;
      rom_top_bit_enable   <= top_bit_next;
      watchdog_flag_one    <= wdf_next;
      gate_function_select <= gate_next;
      pulldown_ctrl_first  <= pull_first_next;
      pulldown_ctrl_second <= pull_second_next;
      timer_one_control    <= t1_ctrl_next;
      timer_two_control    <= t2_ctrl_next;
      reload_timer_two_low <= reload_next;
      ram_we               <= we_next;
      ram_wdata            <= wdata_next;
      if (start) begin
        busy_reg <= 1'b1;
      end else if (fetch_done) begin
        busy_reg <= 1'b0;
      end
      if (reload_next) begin
        // Upper reload nibble to upper count nibble, lower to lower
        timer_two_load_value[7:4] <= timer_two_low_reload[7:4];
        timer_two_load_value[3:0] <= timer_two_low_reload[3:0];
      end
      // Exchange writes back to the address used before X and Y move
      if (we_next) begin
        ram_waddr <= memory_pointer;
      end
    end
  end

  // Read data stand only in the cycle after the read strobe
  always @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr == `OFS_INSTR) begin
      reg_rdata <= {14'h0000, busy_reg, skip_reg};
    end else if (reg_addr == `OFS_AB) begin
      reg_rdata <= {8'h00, b_reg, a_reg};
    end else if (reg_addr == `OFS_XYD) begin
      reg_rdata <= {7'h00, d_reg, x_reg, y_reg};
    end else if (reg_addr == `OFS_E) begin
      reg_rdata <= {8'h00, e_reg};
    end else if (reg_addr == `OFS_TCTRL) begin
      reg_rdata <= {7'h00, timer_two_control, timer_one_control, gate_function_select};
    end else if (reg_addr == `OFS_PULL) begin
      reg_rdata <= {8'h00, pulldown_ctrl_second, pulldown_ctrl_first};
    end else if (reg_addr == `OFS_FLAGS) begin
      reg_rdata <= {13'h0000, watchdog_flag_one, rom_top_bit_enable, carry_bit};
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  rom_fetch_seq u_fetch (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .start      (start),
    .fetch_addr ({op[3:0], d_reg, a_reg}),
    .rom_addr   (rom_addr),
    .rom_rd     (rom_rd),
    .rom_rdata  (rom_rdata),
    .stack_push (stack_push),
    .stack_pop  (stack_pop),
    .done       (fetch_done),
    .word       (fetch_word)
  );

endmodule // nibble_transfer_instruction_unit

// ===== dv/nibble_unit_props.sv
// Concurrent checks on the ports of the nibble transfer instruction unit
`include "nibble_unit_map.vh"
module nibble_unit_props (
  // clock and reset
  input wire        ref_clk,
  input wire        reset,
  // register port
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // timers and watchdog
  input wire [7:0]  timer_one_count,
  input wire [7:0]  timer_two_count,
  input wire [7:0]  timer_two_low_reload,
  input wire        watchdog_expire,
  input wire        reload_timer_two_low,
  input wire [7:0]  timer_two_load_value,
  input wire [2:0]  timer_one_control,
  input wire [3:0]  timer_two_control,
  // control registers and flags
  input wire [1:0]  gate_function_select,
  input wire [3:0]  pulldown_ctrl_first,
  input wire [3:0]  pulldown_ctrl_second,
  input wire        watchdog_flag_one,
  input wire        rom_top_bit_enable,
  input wire        carry_bit,
  // RAM
  input wire [5:0]  memory_pointer,
  input wire [3:0]  ram_rdata,
  input wire [5:0]  ram_waddr,
  input wire [3:0]  ram_wdata,
  input wire        ram_we,
  // ROM and stack
  input wire [10:0] rom_addr,
  input wire        rom_rd,
  input wire [8:0]  rom_rdata,
  input wire        stack_push,
  input wire        stack_pop
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire       ins_wr = reg_wr && (reg_addr == `OFS_INSTR);
  wire [8:0] op     = reg_wdata[8:0];

  sequence fetch_issue;
    rom_rd && stack_push && !stack_pop;
  endsequence
  sequence fetch_close;
    !rom_rd ##1 (stack_pop && !stack_push);
  endsequence

  a_fetch_steps: assert property (rom_rd |-> fetch_issue ##1 fetch_close)
    else $error("table fetch push and pop out of step");
  a_fetch_cause: assert property (
    rom_rd |-> $past(ins_wr && op[8:4] == `GRP_TABLE)
      && rom_addr[10:7] == $past(reg_wdata[3:0]))
    else $error("table fetch without its opcode or wrong page");
  a_carry_source: assert property (
    $changed(carry_bit) |-> rom_top_bit_enable && $past(stack_pop)
      && carry_bit == $past(rom_rdata[8], 2))
    else $error("carry changed other than from ROM bit 8");
  a_top_bit_set: assert property (
    $rose(rom_top_bit_enable) |-> $past(ins_wr && op == `OP_TOP_BIT_SET))
    else $error("top-bit enable set without its opcode");
  a_reload_copy: assert property (
    reload_timer_two_low |-> $past(ins_wr && op == `OP_RELOAD_T2)
      && timer_two_load_value == $past(timer_two_low_reload) ##1 !reload_timer_two_low)
    else $error("timer two reload value or pulse wrong");
  a_wdf_clear: assert property (
    $fell(watchdog_flag_one) |-> $past(ins_wr && op == `OP_WDT_CLEAR))
    else $error("watchdog flag cleared without its opcode");
  a_wdf_set: assert property (watchdog_expire |=> watchdog_flag_one)
    else $error("watchdog flag not set on expiry");
  a_ram_swap: assert property (
    ram_we |-> $past(ins_wr && op[8:4] == 5'h06 && op[3:2] != 2'b01)
      && ram_waddr == $past(memory_pointer)
      && memory_pointer[5:4] == $past(memory_pointer[5:4] ^ reg_wdata[1:0]))
    else $error("RAM exchange address or X update wrong");
  a_step_down: assert property (
    ram_we && $past(reg_wdata[3:2]) == 2'b11
      |-> memory_pointer[3:0] == $past(memory_pointer[3:0]) - 4'h1)
    else $error("Y not decremented by step-down exchange");
  a_step_up: assert property (
    ram_we && $past(reg_wdata[3:2]) == 2'b10
      |-> memory_pointer[3:0] == $past(memory_pointer[3:0]) + 4'h1)
    else $error("Y not incremented by step-up exchange");
  a_t1_ctrl_cause: assert property (
    $changed(timer_one_control) |-> $past(ins_wr && op == `OP_T1_CTRL))
    else $error("timer one control changed without its opcode");
  a_pull_cause: assert property (
    $changed({pulldown_ctrl_second, pulldown_ctrl_first})
      |-> $past(ins_wr && (op == `OP_PULL_FIRST || op == `OP_PULL_SECOND)))
    else $error("pull-down control changed without its opcode");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside its cycle");
endmodule // nibble_unit_props

bind nibble_transfer_instruction_unit nibble_unit_props props (.*);

// ===== dv/nibble_transfer_instruction_unit_tb.sv
// Self-checking bench for the nibble transfer instruction unit
`include "nibble_unit_map.vh"
module nibble_transfer_instruction_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, watchdog_expire = 1'b0;
  logic [7:0]  timer_one_count = 8'h00, timer_two_count = 8'h00, timer_two_low_reload = 8'h00;
  logic [8:0]  rom_rdata = 9'h000;
  wire  [15:0] reg_rdata;
  wire         reload_timer_two_low, watchdog_flag_one, rom_top_bit_enable, carry_bit, ram_we;
  wire         rom_rd, stack_push, stack_pop;
  wire  [7:0]  timer_two_load_value;
  wire  [2:0]  timer_one_control;
  wire  [3:0]  timer_two_control, pulldown_ctrl_first, pulldown_ctrl_second, ram_rdata, ram_wdata;
  wire  [1:0]  gate_function_select;
  wire  [5:0]  memory_pointer, ram_waddr;
  wire  [10:0] rom_addr;
  logic [3:0]  mem [0:63];
  logic [3:0]  ea, eb, ey;
  logic [1:0]  ex;
  logic [2:0]  ed;
  logic [7:0]  ee;
  logic        ecy, eurs, ewdf, eskip;
  logic [15:0] rv;
  int          fail_count = 0;
  int          checks_done = 0;

  always #20 ref_clk = ~ref_clk;
  // Small RAM so that exchanged nibbles really come back on later reads
  assign ram_rdata = mem[memory_pointer];
  always @(posedge ref_clk) if (ram_we) mem[ram_waddr] <= ram_wdata;

  nibble_transfer_instruction_unit uut (.*);

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic exe(input logic [8:0] op);
    wr(`OFS_INSTR, {7'h00, op});
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic chk_ab;
    rd(`OFS_AB);
    check(rv, {8'h00, eb, ea});
  endtask
  task automatic chk_flags;
    rd(`OFS_FLAGS);
    check(rv, {13'h0000, ewdf, eurs, ecy});
  endtask
  // Reading timer one puts a chosen value into A and B in one instruction
  task automatic load_ab(input logic [7:0] v);
    @(posedge ref_clk);
    timer_one_count <= v;
    exe(`OP_READ_T1);
    {eb, ea} = v;
  endtask
  function automatic logic [3:0] gate_fn(input logic [1:0] g, input logic [3:0] a, e);
    case (g)
      `GATE_XOR: gate_fn = a ^ e;
      `GATE_OR:  gate_fn = a | e;
      `GATE_AND: gate_fn = a & e;
      default:   gate_fn = a;
    endcase
  endfunction
  task automatic do_swap(input logic [6:0] grp, input logic [1:0] j);
    logic [5:0] p;
    logic [3:0] m;
    p = {ex, ey};
    m = mem[p];
    exe({grp, j});
    check({ram_we, ram_waddr, ram_wdata, 5'h00}, {1'b1, p, ea, 5'h00});
    ea = m;
    ex = ex ^ j;
    if (grp == `GRP_SWAP_DOWN) ey = ey - 4'h1;
    if (grp == `GRP_SWAP_UP) ey = ey + 4'h1;
    eskip = (grp == `GRP_SWAP_DOWN && ey == 4'hF) || (grp == `GRP_SWAP_UP && ey == 4'h0);
    rd(`OFS_INSTR);
    check(rv, {15'h0000, eskip});
    rd(`OFS_XYD);
    check(rv, {7'h00, ed, ex, ey});
    exe(`OP_COPY_A_TO_B);
    if (!eskip) eb = ea;
    eskip = 1'b0;
    chk_ab;
  endtask
  task automatic fetch(input logic [3:0] p, input logic [8:0] w);
    exe({`GRP_TABLE, p});
    check({rom_rd, stack_push, 3'h0, rom_addr}, {2'b11, 3'h0, p, ed, ea});
    @(posedge ref_clk);
    rom_rdata <= w;
    // The ROM word is only good for one cycle; afterwards show its inverse
    @(posedge ref_clk);
    rom_rdata <= ~w;
    #1;
    check({15'h0000, stack_pop}, 16'h0001);
    {eb, ea} = w[7:0];
    if (eurs) ecy = w[8];
    chk_ab;
    chk_flags;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin : watchdog
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    tally_and_finish;
  end

  initial begin : main
    int i;
    logic [7:0] v;
    logic [1:0] j;
    void'($urandom(32'hA68B3E82));
    for (i = 0; i < 64; i++) mem[i] = 4'($urandom);
    {ea, eb, ey, ex, ed, ee, ecy, eurs, ewdf, eskip} = 29'h0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    chk_flags;
    for (i = 0; i < 12; i++) begin
      v = 8'($urandom);
      j = 2'($urandom);
      load_ab(v);
      chk_ab;
      exe(`OP_COPY_A_TO_B);
      eb = ea;
      chk_ab;
      exe(`OP_WRITE_E);
      ee = {eb, ea};
      rd(`OFS_E);
      check(rv, {8'h00, ee});
      @(posedge ref_clk);
      timer_two_count <= 8'($urandom);
      exe(`OP_READ_T2);
      {eb, ea} = timer_two_count;
      chk_ab;
      exe(`OP_COPY_B_TO_A);
      ea = eb;
      chk_ab;
      exe(`OP_COPY_A_TO_Y);
      ey = ea;
      exe(`OP_PAGE_SEL);
      ed = ea[2:0];
      exe(`OP_READ_E);
      {eb, ea} = ee;
      chk_ab;
      exe(`OP_COPY_Y_TO_A);
      ea = ey;
      rd(`OFS_XYD);
      check(rv, {7'h00, ed, ex, ey});
      chk_ab;
      exe(`OP_T1_CTRL);
      exe(`OP_T2_CTRL);
      exe(`OP_GATE_SEL);
      exe(`OP_PULL_FIRST);
      load_ab(~v);
      exe(`OP_PULL_SECOND);
      check({7'h00, timer_two_control, timer_one_control,
             gate_function_select}, {7'h00, ey, ey[2:0], ey[1:0]});
      check({8'h00, pulldown_ctrl_second, pulldown_ctrl_first}, {8'h00, ea, ey});
      exe(`OP_GATE_OP);
      ea = gate_fn(ey[1:0], ea, ee[3:0]);
      chk_ab;
      @(posedge ref_clk);
      timer_two_low_reload <= 8'($urandom);
      exe(`OP_RELOAD_T2);
      check({7'h00, reload_timer_two_low, timer_two_load_value},
            {8'h01, timer_two_low_reload});
      v[3:0] = mem[{ex, ey}];
      exe({`GRP_LOAD_RAM, j});
      ea = v[3:0];
      ex = ex ^ j;
      chk_ab;
      do_swap(`GRP_SWAP, j);
      do_swap(i[0] ? `GRP_SWAP_UP : `GRP_SWAP_DOWN, ~j);
    end
    load_ab(8'h00);
    exe(`OP_COPY_A_TO_Y);
    ey = ea;
    do_swap(`GRP_SWAP_DOWN, 2'h3);
    load_ab(8'h0F);
    exe(`OP_COPY_A_TO_Y);
    ey = ea;
    do_swap(`GRP_SWAP_UP, 2'h1);
    // Expiry lands on the same edge as a clear: the set has to win
    fork
      exe(`OP_WDT_CLEAR);
      begin
        @(posedge ref_clk);
        watchdog_expire <= 1'b1;
        @(posedge ref_clk);
        watchdog_expire <= 1'b0;
      end
    join
    ewdf = 1'b1;
    chk_flags;
    exe(`OP_WDT_CLEAR);
    ewdf = 1'b0;
    chk_flags;
    load_ab(8'h5A);
    exe(`OP_PAGE_SEL);
    ed = ea[2:0];
    fetch(4'hF, 9'h1C3);
    exe(`OP_TOP_BIT_SET);
    eurs = 1'b1;
    chk_flags;
    fetch(4'h0, 9'h1A5);
    for (i = 0; i < 4; i++) fetch(4'(i * 5), 9'($urandom));
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    {ea, eb, ecy, eurs, ewdf} = 11'h000;
    chk_flags;
    chk_ab;
    tally_and_finish;
  end
endmodule // nibble_transfer_instruction_unit_tb
